// ===== sgp_pkg.sv
package sgp_pkg;
   localparam int SGP_GROUPS = 8;
   localparam int SGP_IDX_W = 3;
   // -------------------------------------------------------------
   // Register map (word aligned byte offsets)
   // -------------------------------------------------------------
   localparam logic [7:0] SGP_ADR_CTRL = 8'h00;
   localparam logic [7:0] SGP_ADR_USED = 8'h04;
   localparam logic [7:0] SGP_ADR_FORCE = 8'h08;
   localparam logic [7:0] SGP_ADR_REMOTE = 8'h0C;
   localparam logic [7:0] SGP_ADR_LOCAL = 8'h10;
   localparam logic [7:0] SGP_ADR_STATUS = 8'h14;
   localparam logic [7:0] SGP_ADR_REQ = 8'h18;
   // CTRL bit: force change enable
   localparam int SGP_CTRL_FORCE_EN = 0;
   // Group select value 0 means none, 1..8 the group
   localparam logic [3:0] SGP_SEL_NONE = 4'h0;
   localparam logic [7:0] SGP_USED_RST = 8'h01;
   localparam logic [7:0] SGP_ACTIVE_RST = 8'h01;
   // STATUS layout
   localparam int SGP_ST_ACT_LSB = 0;
   localparam int SGP_ST_FAIL_NC = 8;
   localparam int SGP_ST_FAIL_LP = 9;
   localparam int SGP_ST_FAIL_FORCE = 10;
   localparam int SGP_ST_FORCE = 11;

   typedef struct packed {
      logic [7:0] enabled_on;
      logic [7:0] enabled_off;
      logic [7:0] req_on;
      logic [7:0] req_off;
      logic [7:0] active_on;
      logic [7:0] active_off;
      logic remote_on;
      logic remote_off;
      logic local_on;
      logic local_off;
      logic force_on;
      logic force_off;
      logic fail_nc_on;
      logic fail_nc_off;
      logic fail_force_on;
      logic fail_force_off;
      logic fail_lp_on;
      logic fail_lp_off;
   } sgp_events_type;
endpackage

// ===== sgp_selector.sv
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Fixed priority, group one highest
// - Group eight never wins while another group requests
// - One-bit requests, inactive at reset
// - Accept pulse or static requests
// - Static group one masks all others
// - Static group n masks higher-numbered groups
// - Static group eight masks nothing
// - Automatic return to group one only when the active group is disabled
// - Enabled/disabled events for groups two-eight
// - Request ON/OFF events per input
// - Active ON/OFF events per group
// - Unconfigured request rejected, failure event
// - Refused lower priority request, failure event
// - Force without preconditions, failure event
// - Remote, local, force events separately
// - Pulse-selected group holds until another
// - Force overrides automatic control
// - Remote cannot beat held higher group
module sgp_selector
   import sgp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] group_req_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [7:0] active_group_o,
   output sgp_events_type events_o
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] req_s1;
      logic [7:0] req_s2;
      logic [7:0] req_prev;
      logic [7:0] used;
      logic [7:0] used_prev;
      logic [7:0] active;
      logic [7:0] active_prev;
      logic force_en;
      logic force_prev;
      logic [3:0] force_sel;
      logic [3:0] remote_sel;
      logic [3:0] local_sel;
      logic remote_pend;
      logic local_pend;
      logic remote_flag;
      logic remote_flag_prev;
      logic local_flag;
      logic local_flag_prev;
      logic fail_nc;
      logic fail_nc_prev;
      logic fail_lp;
      logic fail_lp_prev;
      logic fail_force;
      logic fail_force_prev;
      logic ack;
      logic [31:0] rdat;
   } sgp_state_type;

   sgp_state_type state_q;
   sgp_state_type state_d;

   // Decodes a 1..8 selector into a one-hot group vector
   function automatic logic [7:0] sel_onehot(input logic [3:0] sel);
      logic [7:0] r;
      r = '0;
      if (sel != SGP_SEL_NONE && sel <= 4'(SGP_GROUPS)) begin
         r[3'(sel - 4'h1)] = 1'b1;
      end
      return r;
   endfunction

   // Lowest set bit wins: group one is highest priority
   function automatic logic [7:0] pick_first(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = SGP_GROUPS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   // Mask of groups numbered above the lowest held request
   function automatic logic [7:0] above_mask(input logic [7:0] held);
      logic [7:0] r;
      r = '0;
      for (int i = 1; i < SGP_GROUPS; i++) begin
         r[i] = r[i-1] | held[i-1];
      end
      return r;
   endfunction

   logic wb_hit;
   logic [7:0] req_rise;
   logic [7:0] masked;
   logic [7:0] blocked;
   logic [7:0] want;
   logic [7:0] winner;
   logic [7:0] remote_v;
   logic [7:0] local_v;
   logic [7:0] force_v;

   assign wb_hit = wb_cyc_i && wb_stb_i && !state_q.ack;
   assign wb_ack_o = state_q.ack;
   assign wb_dat_o = state_q.rdat;
   assign active_group_o = state_q.active;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.req_s1 = group_req_i;
      state_d.req_s2 = state_q.req_s1;
      state_d.req_prev = state_q.req_s2;
      state_d.used_prev = state_q.used;
      state_d.active_prev = state_q.active;
      state_d.force_prev = state_q.force_en;
      state_d.remote_flag_prev = state_q.remote_flag;
      state_d.local_flag_prev = state_q.local_flag;
      state_d.fail_nc_prev = state_q.fail_nc;
      state_d.fail_lp_prev = state_q.fail_lp;
      state_d.fail_force_prev = state_q.fail_force;
      state_d.ack = 1'b0;
      state_d.fail_nc = 1'b0;
      state_d.fail_lp = 1'b0;
      state_d.fail_force = 1'b0;
      state_d.remote_flag = 1'b0;
      state_d.local_flag = 1'b0;
      state_d.remote_pend = 1'b0;
      state_d.local_pend = 1'b0;

      // Rising edge is a pulse request; held level masks lower groups
      req_rise = state_q.req_s2 & ~state_q.req_prev;
      masked = above_mask(state_q.req_s2);
      remote_v = state_q.remote_pend ? sel_onehot(state_q.remote_sel) : 8'h00;
      local_v = state_q.local_pend ? sel_onehot(state_q.local_sel) : 8'h00;
      force_v = sel_onehot(state_q.force_sel);
      want = (req_rise | (state_q.req_s2 & ~state_q.active) | remote_v | local_v)
         & ~masked;
      blocked = (req_rise | remote_v | local_v) & masked;
      winner = pick_first(want & state_q.used);

      if (state_q.force_en) begin
         // User-selected group overrides automatic control
         if ((force_v & state_q.used) != 8'h00) begin
            state_d.active = force_v;
         end else if (force_v != 8'h00) begin
            state_d.fail_force = 1'b1;
         end
      end else if (winner != 8'h00) begin
         state_d.active = winner;
      end
      if ((want & ~state_q.used) != 8'h00) begin
         state_d.fail_nc = 1'b1;
      end
      if (blocked != 8'h00 && !state_q.force_en) begin
         state_d.fail_lp = 1'b1;
      end
      if ((state_d.active & state_q.used) == 8'h00) begin
         state_d.active = SGP_ACTIVE_RST;
      end

      // Register bus
      state_d.rdat = '0;
      if (wb_hit) begin
         state_d.ack = 1'b1;
         if (wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
               SGP_ADR_CTRL: state_d.force_en = wb_dat_i[SGP_CTRL_FORCE_EN];
               SGP_ADR_USED: state_d.used = wb_dat_i[7:0] | SGP_USED_RST;
               SGP_ADR_FORCE: begin
                  state_d.force_sel = wb_dat_i[3:0];
                  if (!state_q.force_en) begin
                     state_d.fail_force = 1'b1;
                  end
               end
               SGP_ADR_REMOTE: begin
                  state_d.remote_sel = wb_dat_i[3:0];
                  state_d.remote_pend = 1'b1;
                  state_d.remote_flag = 1'b1;
               end
               SGP_ADR_LOCAL: begin
                  state_d.local_sel = wb_dat_i[3:0];
                  state_d.local_pend = 1'b1;
                  state_d.local_flag = 1'b1;
               end
               default: ;
            endcase
         end else if (!wb_we_i) begin
            case (wb_adr_i)
               SGP_ADR_CTRL: state_d.rdat[SGP_CTRL_FORCE_EN] = state_q.force_en;
               SGP_ADR_USED: state_d.rdat[7:0] = state_q.used;
               SGP_ADR_FORCE: state_d.rdat[3:0] = state_q.force_sel;
               SGP_ADR_REMOTE: state_d.rdat[3:0] = state_q.remote_sel;
               SGP_ADR_LOCAL: state_d.rdat[3:0] = state_q.local_sel;
               SGP_ADR_STATUS: begin
                  state_d.rdat[SGP_ST_ACT_LSB +: 8] = state_q.active;
                  state_d.rdat[SGP_ST_FAIL_NC] = state_q.fail_nc;
                  state_d.rdat[SGP_ST_FAIL_LP] = state_q.fail_lp;
                  state_d.rdat[SGP_ST_FAIL_FORCE] = state_q.fail_force;
                  state_d.rdat[SGP_ST_FORCE] = state_q.force_en;
               end
               SGP_ADR_REQ: state_d.rdat[7:0] = state_q.req_s2;
               default: state_d.rdat = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= '0;
         state_q.used <= SGP_USED_RST;
         state_q.used_prev <= SGP_USED_RST;
         state_q.active <= SGP_ACTIVE_RST;
         state_q.active_prev <= SGP_ACTIVE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // -------------------------------------------------------------
   // Event strobes
   // -------------------------------------------------------------
   always_comb begin
      events_o.enabled_on = state_q.used & ~state_q.used_prev & 8'hFE;
      events_o.enabled_off = ~state_q.used & state_q.used_prev & 8'hFE;
      events_o.req_on = state_q.req_s2 & ~state_q.req_prev;
      events_o.req_off = ~state_q.req_s2 & state_q.req_prev;
      events_o.active_on = state_q.active & ~state_q.active_prev;
      events_o.active_off = ~state_q.active & state_q.active_prev;
      events_o.remote_on = state_q.remote_flag & ~state_q.remote_flag_prev;
      events_o.remote_off = ~state_q.remote_flag & state_q.remote_flag_prev;
      events_o.local_on = state_q.local_flag & ~state_q.local_flag_prev;
      events_o.local_off = ~state_q.local_flag & state_q.local_flag_prev;
      events_o.force_on = state_q.force_en & ~state_q.force_prev;
      events_o.force_off = ~state_q.force_en & state_q.force_prev;
      events_o.fail_nc_on = state_q.fail_nc & ~state_q.fail_nc_prev;
      events_o.fail_nc_off = ~state_q.fail_nc & state_q.fail_nc_prev;
      events_o.fail_force_on = state_q.fail_force & ~state_q.fail_force_prev;
      events_o.fail_force_off = ~state_q.fail_force & state_q.fail_force_prev;
      events_o.fail_lp_on = state_q.fail_lp & ~state_q.fail_lp_prev;
      events_o.fail_lp_off = ~state_q.fail_lp & state_q.fail_lp_prev;
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_onehot;
      @(posedge clk_i) disable iff (rst_i) $onehot(state_q.active);
   endproperty
   a_onehot: assert property (p_onehot) else $error("active not one-hot");

   property p_g1_static;
      @(posedge clk_i) disable iff (rst_i)
         (state_q.req_s2[0] && $past(state_q.req_s2[0]) && !state_q.force_en)
         |=> state_q.active[0];
   endproperty
   a_g1_static: assert property (p_g1_static) else $error("static group one lost");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
         (want == 8'h00 && !state_q.force_en && (state_q.active & state_q.used) != 8'h00)
         |=> $stable(state_q.active);
   endproperty
   a_hold: assert property (p_hold) else $error("active changed without request");

   property p_g8_never_displaces;
      @(posedge clk_i) disable iff (rst_i)
         (!state_q.force_en && !state_q.active[7] && (want & state_q.used & 8'h7F) != 8'h00)
         |=> !state_q.active[7];
   endproperty
   a_g8_never_displaces: assert property (p_g8_never_displaces)
      else $error("group eight displaced another");

   property p_masked;
      @(posedge clk_i) disable iff (rst_i)
         (!state_q.force_en && state_q.req_s2[1]) |=> (state_q.active & 8'hFC) == 8'h00
            || $past(state_q.active & 8'hFC) == (state_q.active & 8'hFC);
   endproperty
   a_masked: assert property (p_masked) else $error("masked group activated");

   property p_req_event;
      @(posedge clk_i) disable iff (rst_i)
         events_o.req_on[0] |-> state_q.req_s2[0] ##1 !events_o.req_on[0];
   endproperty
   a_req_event: assert property (p_req_event) else $error("request event not a strobe");

   property p_active_event;
      @(posedge clk_i) disable iff (rst_i)
         $changed(state_q.active) |-> (events_o.active_on != 8'h00 && events_o.active_off != 8'h00);
   endproperty
   a_active_event: assert property (p_active_event) else $error("missing active event");

   property p_force;
      @(posedge clk_i) disable iff (rst_i)
         (state_q.force_en && (force_v & state_q.used) != 8'h00) |=> state_q.active == $past(force_v);
   endproperty
   a_force: assert property (p_force) else $error("force not applied");

   property p_nc;
      @(posedge clk_i) disable iff (rst_i)
         ((want & ~state_q.used) != 8'h00) |=> state_q.fail_nc;
   endproperty
   a_nc: assert property (p_nc) else $error("no not-configured fail");

   property p_lp;
      @(posedge clk_i) disable iff (rst_i)
         (!state_q.force_en && blocked != 8'h00) |=> state_q.fail_lp;
   endproperty
   a_lp: assert property (p_lp) else $error("no lower-priority fail");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i) wb_hit |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bad bus ack");

   c_pulse_change: cover property (@(posedge clk_i) disable iff (rst_i)
      events_o.active_on[2]);
   c_force: cover property (@(posedge clk_i) disable iff (rst_i) events_o.force_on);
   c_lp_fail: cover property (@(posedge clk_i) disable iff (rst_i) events_o.fail_lp_on);
   c_remote: cover property (@(posedge clk_i) disable iff (rst_i)
      events_o.remote_on);

endmodule // sgp_selector

// ===== sgp_relay_logic.sv
`timescale 1ns/1ps
module sgp_relay_logic
   import sgp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] level_i,
   input wire logic [7:0] pulse_i,
   output logic [7:0] req_o
);
   // -------------------------------------------------------------
   // Request lines: static levels and one-clock pulses
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_o <= 8'h00;
      end else begin
         req_o <= level_i | pulse_i;
      end
   end
endmodule // sgp_relay_logic

// ===== sgp_selector_test.sv
`timescale 1ns/1ps
module sgp_selector_test;
   import sgp_pkg::*;
   typedef struct packed {
      logic [7:0] lvl;
      logic [7:0] pls;
      logic [7:0] act;
   } sgp_row_type;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] lvl = 8'h00;
   logic [7:0] pls = 8'h00;
   logic [7:0] req;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic ack;
   logic [7:0] act;
   sgp_events_type ev;
   sgp_events_type ev_seen = '0;
   logic [3:0] sel = 4'h0;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   sgp_row_type rows [8] = '{
      '{8'h02, 8'h00, 8'h02}, '{8'h12, 8'h00, 8'h02}, '{8'h03, 8'h00, 8'h01},
      '{8'h88, 8'h00, 8'h08}, '{8'h80, 8'h00, 8'h80}, '{8'h00, 8'h00, 8'h80},
      '{8'h00, 8'h20, 8'h20}, '{8'h00, 8'h00, 8'h20}};

   always #20 clk_i = ~clk_i;

   sgp_relay_logic u_src (
      .clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .pulse_i(pls), .req_o(req));

   sgp_selector u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .group_req_i(req), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .active_group_o(act), .events_o(ev));

   // -------------------------------------------------------------
   // Event capture and hang guard
   // -------------------------------------------------------------
   always @(negedge clk_i) begin
      ev_seen = ev_seen | ev;
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      do @(negedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      @(posedge clk_i);
   endtask

   task automatic step(input logic [7:0] l, input logic [7:0] p);
      @(posedge clk_i);
      lvl <= l;
      pls <= p;
      @(posedge clk_i);
      pls <= 8'h00;
      repeat (6) @(posedge clk_i);
   endtask

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({24'h0, act}, 32'h01);
      step(8'h00, 8'h04);
      check({24'h0, act}, 32'h01);
      check({31'h0, ev_seen.fail_nc_on}, 32'h1);
      wb(1'b0, 8'hFC, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, SGP_ADR_USED, 32'hFF);
      check({24'h0, ev_seen.enabled_on}, 32'hFE);
      wb(1'b0, SGP_ADR_USED, 32'h0);
      check(rd, 32'hFF);
      foreach (rows[i]) begin
         step(rows[i].lvl, rows[i].pls);
         check({24'h0, act}, {24'h0, rows[i].act});
      end
      check({31'h0, ev_seen.active_on[5]}, 32'h1);
      check({31'h0, ev_seen.fail_lp_on}, 32'h1);
      check({31'h0, ev_seen.req_off[1]}, 32'h1);
      step(8'h01, 8'h00);
      wb(1'b1, SGP_ADR_REMOTE, 32'h3);
      repeat (6) @(posedge clk_i);
      check({24'h0, act}, 32'h01);
      step(8'h00, 8'h00);
      wb(1'b1, SGP_ADR_REMOTE, 32'h3);
      check({24'h0, act}, 32'h04);
      check({30'h0, ev_seen.remote_on, ev_seen.remote_off}, 32'h3);
      wb(1'b1, SGP_ADR_LOCAL, 32'h2);
      check({24'h0, act}, 32'h02);
      check({30'h0, ev_seen.local_on, ev_seen.local_off}, 32'h3);
      wb(1'b1, SGP_ADR_FORCE, 32'h5);
      check({31'h0, ev_seen.fail_force_on}, 32'h1);
      wb(1'b1, SGP_ADR_CTRL, 32'h1);
      check({24'h0, act}, 32'h10);
      wb(1'b0, SGP_ADR_STATUS, 32'h0);
      check(rd, 32'h810);
      wb(1'b1, SGP_ADR_CTRL, 32'h0);
      check({30'h0, ev_seen.force_on, ev_seen.force_off}, 32'h3);
      check({24'h0, act}, 32'h10);
      step(8'h00, 8'h01);
      check({24'h0, act}, 32'h01);
      // Mid-run reset must restore the used mask and group one
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({24'h0, act}, 32'h01);
      wb(1'b0, SGP_ADR_USED, 32'h0);
      check(rd, 32'h01);
      report_and_stop();
   end
endmodule // sgp_selector_test
